// ### dcb_pkg.sv
// Package: constants, types and register map of the dual counter block
// ==========================================================================
// ==========================================================================
package dcb_pkg;

  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;

  // APB register map, byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_LIVE = 12'h008;
  localparam logic [11:0] ADDR_SNAP = 12'h00C;
  localparam logic [11:0] ADDR_BYTE = 12'h010;

  // CTRL fields: software pins when external pins are not used
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_STEP_A_BIT = 1;
  localparam int CTRL_STEP_B_BIT = 2;
  localparam int CTRL_CAPTURE_BIT = 3;
  localparam int CTRL_CHAIN_BIT = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // STATUS fields
  localparam int STAT_FULL_N_BIT = 0;
  localparam int STAT_DRIVE_BIT = 1;

  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [31:0] SNAP_RESET = 32'h0000_0000;

  typedef struct packed {
    logic gate_second_high_byte_n;
    logic gate_second_low_byte_n;
    logic gate_first_high_byte_n;
    logic gate_first_low_byte_n;
  } dcb_gates_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic oe_n;
  } dcb_byte_bus_t;

endpackage

// ### dcb_edge.sv
// Rising-edge detector for inputs sampled on pclk
`timescale 1ns/10ps
module dcb_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level_in,
  output logic rise
);
  logic prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end

  assign rise = level_in & ~prev_reg;
endmodule // dcb_edge

// ### dcb_top.sv
// Dual 16-bit counter with snapshot register and byte readout bus
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module dcb_top
  import dcb_pkg::*;
#(
  parameter int CNT_WIDTH = dcb_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_clear_n,
  input wire logic count_clock_first,
  input wire logic count_clock_second,
  input wire logic second_count_enable_n,
  input wire logic register_clock,
  input wire dcb_pkg::dcb_gates_t gates_n,
  output logic first_full_count_n,
  output logic [7:0] byte_out_bus,
  output logic byte_out_oe_n
);
  import dcb_pkg::*;

  logic [CNT_WIDTH-1:0] cnt_a_reg;
  logic [CNT_WIDTH-1:0] cnt_b_reg;
  // Fixed 32-bit image; narrower counters are zero-extended into it
  logic [2*CNT_W-1:0] snap_reg;
  logic [31:0] ctrl_reg;
  logic rise_a;
  logic rise_b;
  logic rise_r;
  logic step_a;
  logic step_b;
  logic capture;
  logic clear_now;
  logic full_a;
  logic en_b_n;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] rd_next;
  logic rd_err;
  dcb_byte_bus_t bus_next;

  function automatic logic all_ones(input logic [CNT_WIDTH-1:0] v);
    return &v;
  endfunction

  // ==========================================================================
  // Count clock and register clock edges, sampled on pclk
  // ==========================================================================
  dcb_edge u_edge_a (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(count_clock_first),
    .rise(rise_a)
  );

  dcb_edge u_edge_b (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(count_clock_second),
    .rise(rise_b)
  );

  dcb_edge u_edge_r (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(register_clock),
    .rise(rise_r)
  );

  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;

  // Software strobes act as extra count clock and register clock edges
  assign step_a = rise_a |
    (apb_wr && paddr == ADDR_CTRL && pwdata[CTRL_STEP_A_BIT]);
  assign step_b = rise_b |
    (apb_wr && paddr == ADDR_CTRL && pwdata[CTRL_STEP_B_BIT]);
  assign capture = rise_r |
    (apb_wr && paddr == ADDR_CTRL && pwdata[CTRL_CAPTURE_BIT]);
  // Clear pin is sampled synchronously; a held clear bit also clears
  assign clear_now = ~counter_clear_n | ctrl_reg[CTRL_CLEAR_BIT];
  assign full_a = all_ones(cnt_a_reg);
  // Chain bit ties enable to the flag inside, as the pin strap would
  assign en_b_n = ctrl_reg[CTRL_CHAIN_BIT] ?
    ~full_a : second_count_enable_n;

  // ==========================================================================
  // Control register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_reg <= {27'h0, pwdata[CTRL_CHAIN_BIT], 3'h0,
        pwdata[CTRL_CLEAR_BIT]};
    end
  end

  // ==========================================================================
  // Counters
  // ==========================================================================
  // Clear overrides counting in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_a_reg <= CNT_WIDTH'(CNT_RESET);
    end else if (clear_now) begin
      cnt_a_reg <= CNT_WIDTH'(CNT_RESET);
    end else if (step_a) begin
      cnt_a_reg <= cnt_a_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_b_reg <= CNT_WIDTH'(CNT_RESET);
    end else if (clear_now) begin
      cnt_b_reg <= CNT_WIDTH'(CNT_RESET);
    end else if (step_b && !en_b_n) begin
      cnt_b_reg <= cnt_b_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_full_count_n <= 1'b1;
    end else if (clear_now) begin
      first_full_count_n <= 1'b1;
    end else if (step_a) begin
      first_full_count_n <= ~(cnt_a_reg == {{(CNT_WIDTH-1){1'b1}}, 1'b0});
    end else begin
      first_full_count_n <= ~full_a;
    end
  end

  // ==========================================================================
  // Snapshot
  // ==========================================================================
  // Holds between captures regardless of counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_reg <= SNAP_RESET;
    end else if (capture) begin
      snap_reg <= {CNT_W'(cnt_b_reg),
        CNT_W'(cnt_a_reg)};
    end
  end

  // ==========================================================================
  // Byte readout
  // ==========================================================================
  // Reader must assert one gate only; priority below is a fallback
  always_comb begin
    bus_next.data = 8'h00;
    bus_next.oe_n = 1'b0;
    if (!gates_n.gate_first_low_byte_n) begin
      bus_next.data = snap_reg[7:0];
    end else if (!gates_n.gate_first_high_byte_n) begin
      bus_next.data = snap_reg[15:8];
    end else if (!gates_n.gate_second_low_byte_n) begin
      bus_next.data = snap_reg[23:16];
    end else if (!gates_n.gate_second_high_byte_n) begin
      bus_next.data = snap_reg[31:24];
    end else begin
      bus_next.oe_n = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_out_bus <= 8'h00;
      byte_out_oe_n <= 1'b1;
    end else begin
      byte_out_bus <= bus_next.data;
      byte_out_oe_n <= bus_next.oe_n;
    end
  end

  // ==========================================================================
  // APB read side
  // ==========================================================================
  always_comb begin
    rd_next = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == ADDR_CTRL) begin
      rd_next = ctrl_reg;
    end else if (paddr == ADDR_STATUS) begin
      rd_next[STAT_FULL_N_BIT] = first_full_count_n;
      rd_next[STAT_DRIVE_BIT] = ~byte_out_oe_n;
    end else if (paddr == ADDR_LIVE) begin
      rd_next = {CNT_W'(cnt_b_reg), CNT_W'(cnt_a_reg)};
    end else if (paddr == ADDR_SNAP) begin
      rd_next = snap_reg;
    end else if (paddr == ADDR_BYTE) begin
      rd_next = {24'h0, byte_out_bus};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Zero-wait answer: pready high in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  logic unused_rd;
  assign unused_rd = apb_rd;
endmodule // dcb_top

// ### dcb_top_checker.sv
// Assertion checker for the dual counter block ports
`timescale 1ns/10ps
module dcb_top_checker
  import dcb_pkg::*;
#(
  parameter int CNT_WIDTH = dcb_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic counter_clear_n,
  input wire logic count_clock_first,
  input wire logic register_clock,
  input wire dcb_pkg::dcb_gates_t gates_n,
  input wire logic first_full_count_n,
  input wire logic [7:0] byte_out_bus,
  input wire logic byte_out_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Sequences
  sequence seq_step_first;
    !count_clock_first ##1 count_clock_first;
  endsequence
  sequence seq_setup;
    psel && !penable;
  endsequence
  // ==========================================================
  // Properties
  chk_idle_float: assert property (gates_n == 4'hF |=> byte_out_oe_n)
    else $error("bus driven with all gates off");
  chk_gate_drive: assert property (gates_n != 4'hF |=> !byte_out_oe_n)
    else $error("bus not driven while a gate is low");
  chk_clear_flag: assert property (!counter_clear_n |-> ##2 first_full_count_n)
    else $error("full flag low after clear");
  chk_flag_cause: assert property (!first_full_count_n |-> $past(counter_clear_n, 2))
    else $error("full flag low too soon after clear");
  chk_wrap_flag: assert property (seq_step_first ##0 !first_full_count_n |-> ##2 first_full_count_n)
    else $error("full flag stayed low after wrap");
  chk_snap_hold: assert property ((gates_n == 4'hE && !register_clock) [*3] |-> $stable(byte_out_bus))
    else $error("stored byte changed without capture");
  chk_ready_setup: assert property (seq_setup |=> pready)
    else $error("no ready in access phase");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // dcb_top_checker

bind dcb_top dcb_top_checker #(.CNT_WIDTH(CNT_WIDTH)) i_dcb_top_checker (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .counter_clear_n,
  .count_clock_first, .register_clock, .gates_n, .first_full_count_n,
  .byte_out_bus, .byte_out_oe_n);

// ### dcb_reader.sv
// Host reader model: register clock strobe and byte gates
`timescale 1ns/10ps
module dcb_reader
  import dcb_pkg::*;
(
  input wire logic pclk,
  input wire logic [7:0] bus_wire,
  output logic register_clock,
  output dcb_pkg::dcb_gates_t gates_n
);
  initial begin
    register_clock = 1'b0;
    gates_n = 4'hF;
  end
  // Strobe first so all four bytes share one snapshot
  task automatic capture();
    @(posedge pclk) register_clock <= 1'b1;
    @(posedge pclk) register_clock <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // Only one gate low at a time, all high between reads
  task automatic read_byte(input int idx, output logic [7:0] d);
    @(posedge pclk) gates_n <= ~(4'h1 << idx);
    repeat (2) @(posedge pclk);
    #1 d = bus_wire;
    @(posedge pclk) gates_n <= 4'hF;
    @(posedge pclk);
  endtask
endmodule // dcb_reader

// ### dcb_top_tb.sv
// Self-checking testbench for the dual counter block
`timescale 1ns/10ps
module dcb_top_tb;
  import dcb_pkg::*;
  localparam int W = 12;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic clr_n, ca, cb, en_n, chain, rclk, full_n, oe_n;
  logic [7:0] bus, bus_wire;
  dcb_gates_t gates_n;
  int fail_count, compares;
  // Released bus floats
  assign bus_wire = oe_n ? 8'hZZ : bus;
  dcb_top #(.CNT_WIDTH(W)) i_dcb_top (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .counter_clear_n(clr_n), .count_clock_first(ca),
    .count_clock_second(cb),
    .second_count_enable_n(chain ? full_n : en_n),
    .register_clock(rclk), .gates_n, .first_full_count_n(full_n),
    .byte_out_bus(bus), .byte_out_oe_n(oe_n));
  dcb_reader i_dcb_reader (.pclk, .bus_wire, .register_clock(rclk),
    .gates_n);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Extra low cycle lets the full flag settle before the next rise
  task automatic step(input logic a, input logic b, input int n);
    repeat (n) begin
      @(posedge pclk);
      ca <= a;
      cb <= b;
      @(posedge pclk);
      ca <= 1'b0;
      cb <= 1'b0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic snap(input logic cap, input logic [31:0] exp);
    logic [7:0] d;
    if (cap) i_dcb_reader.capture();
    for (int i = 0; i < 4; i++) begin
      i_dcb_reader.read_byte(i, d);
      check(d, exp[8*i +: 8]);
    end
  endtask
  task automatic test_regs();
    check(bus_wire, 8'hZZ);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, CTRL_RESET);
    apb(1'b1, 12'hFFC, 32'h1);
    check(err, 1'b1);
    snap(1'b1, 32'h0);
  endtask
  task automatic test_count();
    step(1'b1, 1'b0, 291);
    en_n <= 1'b0;
    step(1'b0, 1'b1, 5);
    en_n <= 1'b1;
    step(1'b0, 1'b1, 3);
    snap(1'b1, 32'h0005_0123);
    apb(1'b1, ADDR_CTRL, 32'h8);
    apb(1'b0, ADDR_SNAP, 32'h0);
    check(rd, 32'h0005_0123);
  endtask
  task automatic test_hold_clear();
    step(1'b1, 1'b0, 4);
    snap(1'b0, 32'h0005_0123);
    clr_n <= 1'b0;
    repeat (2) @(posedge pclk);
    clr_n <= 1'b1;
    snap(1'b1, 32'h0);
  endtask
  task automatic test_chain();
    chain <= 1'b1;
    step(1'b1, 1'b1, 4095);
    check(full_n, 1'b0);
    step(1'b1, 1'b1, 3);
    snap(1'b1, 32'h0001_0002);
  endtask
  // Software strobes, held clear and chain bit over the register bus
  task automatic test_soft();
    chain <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h14);
    apb(1'b0, ADDR_LIVE, 32'h0);
    check(rd, 32'h0001_0003);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b0, ADDR_LIVE, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0);
  endtask
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Runs are about 13k cycles; 50k means a hang
  initial begin
    #500_000;
    fail_count++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ca, cb, chain} = '0;
    {clr_n, en_n} = 2'b11;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_count();
    test_hold_clear();
    test_chain();
    test_soft();
    finish_test();
  end
endmodule // dcb_top_tb
